// File: hw/link_status_pkg.sv
// Constants for the link status and alias register slice.
// Assumes a byte-wide register port on the device clock.
package link_status_pkg;
    localparam logic [7:0]  ADDR_RESET_CTRL  = 8'h04;
    localparam logic [7:0]  ADDR_TARGET      = 8'h07;
    localparam logic [7:0]  ADDR_ALIAS       = 8'h08;
    localparam logic [7:0]  ADDR_CRC_LOW     = 8'h0A;
    localparam logic [7:0]  ADDR_CRC_HIGH    = 8'h0B;
    localparam logic [7:0]  ADDR_STATUS      = 8'h0C;
    localparam int          CRC_RESET_BIT    = 5;
    localparam int          ST_LINK_LOST     = 4;
    localparam int          ST_SELFTEST_ERR  = 3;
    localparam int          ST_CLOCK_PRESENT = 2;
    localparam int          ST_NORMAL_ERR    = 1;
    localparam int          ST_LINK_DETECT   = 0;
    localparam logic [7:0]  RESET_BYTE       = 8'h00;
    localparam logic [15:0] CRC_COUNT_MAX    = 16'hFFFF;
    localparam logic [6:0]  ALIAS_RESET      = 7'h00;
    localparam logic [6:0]  ALIAS_OFF        = 7'h00;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    localparam logic        FLAG_RESET       = 1'h0;
endpackage

// File: hw/input_sync.sv
// Two-flop synchroniser for a group of level inputs.
// Assumes inputs come from outside the core clock domain.
`timescale 1ns/1ns
module input_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rstSyncN,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_q;

    always_ff @(posedge core_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            stage1_q <= '0;
            syncOut  <= '0;
        end
        else
        begin
            stage1_q <= asyncIn;
            syncOut  <= stage1_q;
        end
    end
endmodule

// File: hw/link_status_alias_regs.sv
// Register slice: target alias, back-channel CRC counter, link status.
// Assumes the serial control bus front end presents byte reads and writes
// as one-cycle strobes on core_clk, and event inputs are pin levels.
`timescale 1ns/1ns
module link_status_alias_regs
    import link_status_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    output logic      [7:0] regRdData_q,
    input  wire logic       linkDetectIn,
    input  wire logic       videoClockIn,
    input  wire logic       crcErrorIn,
    input  wire logic       selftestActiveIn,
    input  wire logic [6:0] xferAddr,
    input  wire logic       xferValid,
    output logic            fwdValid_q,
    output logic      [6:0] fwdAddr_q,
    output logic            fwdRefused_q
);
    logic [1:0]  rstSync_q;
    logic        rstSyncN;
    logic [3:0]  pinSync;
    logic        linkUp;
    logic        videoInputClockPresent;
    logic        crcErrLvl;
    logic        selftestOn;
    logic        linkUpPrev_q;
    logic        crcErrPrev_q;
    logic        selftestPrev_q;
    logic        linkLossEv;
    logic        crcErrEv;
    logic        selftestStartEv;
    logic        crcReset;
    logic        crcAtMax;
    logic        aliasHit;
    logic [6:0]  remoteTargetAliasZero_q;
    logic [6:0]  remoteTargetAddressZero_q;
    logic [15:0] crcCount_q;
    logic        linkLost_q;
    logic        selftestChecksumFault_q;
    logic        normalFault_q;
    logic [7:0]  statusByte;

    // One compare shared by the write and read decoders
    function automatic logic addr_is(input logic [7:0] addr,
                                     input logic [7:0] want);
        return addr == want;
    endfunction

    // Reset is released through two flops
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            rstSync_q <= 2'h0;
        else
            rstSync_q <= {rstSync_q[0], 1'h1};
    end
    assign rstSyncN = rstSync_q[1];

    // Every pin is a slow level, so a plain two-flop stage is enough
    input_sync #(.WIDTH(4)) u_pins (
        .core_clk (core_clk),
        .rstSyncN (rstSyncN),
        .asyncIn  ({selftestActiveIn, crcErrorIn, videoClockIn,
                    linkDetectIn}),
        .syncOut  (pinSync)
    );
    assign linkUp                 = pinSync[0];
    assign videoInputClockPresent = pinSync[1];
    assign crcErrLvl              = pinSync[2];
    assign selftestOn             = pinSync[3];

    // Previous pin levels for the edge detectors
    always_ff @(posedge core_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            linkUpPrev_q   <= FLAG_RESET;
            crcErrPrev_q   <= FLAG_RESET;
            selftestPrev_q <= FLAG_RESET;
        end
        else
        begin
            linkUpPrev_q   <= linkUp;
            crcErrPrev_q   <= crcErrLvl;
            selftestPrev_q <= selftestOn;
        end
    end

    // Each rising edge of the error input is one CRC error
    assign linkLossEv      = linkUpPrev_q & ~linkUp;
    assign crcErrEv        = crcErrLvl & ~crcErrPrev_q;
    assign selftestStartEv = selftestOn & ~selftestPrev_q;

    // The reset bit acts as a self-clearing strobe, so it is not stored
    assign crcReset = regWrEn && addr_is(regAddr, ADDR_RESET_CTRL)
                      && regWrData[CRC_RESET_BIT];

    // Holding at the top keeps a flood of errors from reading as few
    assign crcAtMax = (crcCount_q == CRC_COUNT_MAX);

    // Bit 0 of the alias and target bytes is reserved and not stored
    always_ff @(posedge core_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            remoteTargetAliasZero_q   <= ALIAS_RESET;
            remoteTargetAddressZero_q <= ALIAS_RESET;
        end
        else if (regWrEn)
        begin
            if (addr_is(regAddr, ADDR_ALIAS))
                remoteTargetAliasZero_q <= regWrData[7:1];
            else if (addr_is(regAddr, ADDR_TARGET))
                remoteTargetAddressZero_q <= regWrData[7:1];
        end
    end

    // Counter: reset wins over a same-cycle error so the clear is clean
    always_ff @(posedge core_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            crcCount_q <= COUNT_RESET;
        else if (crcReset)
            crcCount_q <= COUNT_RESET;
        else if (crcErrEv && !crcAtMax)
            crcCount_q <= crcCount_q + 16'h0001;
    end

    // Sticky flags: a new event wins over a same-cycle clear
    always_ff @(posedge core_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            linkLost_q <= FLAG_RESET;
        else if (linkLossEv)
            linkLost_q <= 1'h1;
        else if (crcReset)
            linkLost_q <= 1'h0;
    end

    // A self-test restart starts its fault record afresh
    always_ff @(posedge core_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            selftestChecksumFault_q <= FLAG_RESET;
        else if (crcErrEv && selftestOn)
            selftestChecksumFault_q <= 1'h1;
        else if (linkLossEv || selftestStartEv || crcReset)
            selftestChecksumFault_q <= 1'h0;
    end

    // Errors in normal traffic are kept apart from self-test ones
    always_ff @(posedge core_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            normalFault_q <= FLAG_RESET;
        else if (crcErrEv && !selftestOn)
            normalFault_q <= 1'h1;
        else if (linkLossEv || crcReset)
            normalFault_q <= 1'h0;
    end

    // Bits 7:5 are reserved and read as zero
    always_comb
    begin
        statusByte                   = RESET_BYTE;
        statusByte[ST_LINK_LOST]     = linkLost_q;
        statusByte[ST_SELFTEST_ERR]  = selftestChecksumFault_q;
        statusByte[ST_CLOCK_PRESENT] = videoInputClockPresent;
        statusByte[ST_NORMAL_ERR]    = normalFault_q;
        statusByte[ST_LINK_DETECT]   = linkUp;
    end

    // Read data is registered one cycle after the read strobe
    always_ff @(posedge core_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            regRdData_q <= RESET_BYTE;
        else if (regRdEn)
        begin
            if (addr_is(regAddr, ADDR_ALIAS))
                regRdData_q <= {remoteTargetAliasZero_q, 1'h0};
            else if (addr_is(regAddr, ADDR_TARGET))
                regRdData_q <= {remoteTargetAddressZero_q, 1'h0};
            else if (addr_is(regAddr, ADDR_CRC_LOW))
                regRdData_q <= crcCount_q[7:0];
            else if (addr_is(regAddr, ADDR_CRC_HIGH))
                regRdData_q <= crcCount_q[15:8];
            else if (addr_is(regAddr, ADDR_STATUS))
                regRdData_q <= statusByte;
            else
                regRdData_q <= RESET_BYTE;
        end
    end

    // A zero alias can never match, which is what keeps target zero shut
    assign aliasHit = xferValid && remoteTargetAliasZero_q != ALIAS_OFF
                      && xferAddr == remoteTargetAliasZero_q;

    // Only target zero is remapped; every other address is refused
    always_ff @(posedge core_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            fwdValid_q   <= FLAG_RESET;
            fwdAddr_q    <= ALIAS_RESET;
            fwdRefused_q <= FLAG_RESET;
        end
        else
        begin
            fwdValid_q   <= 1'h0;
            fwdRefused_q <= 1'h0;
            if (aliasHit)
            begin
                fwdValid_q <= 1'h1;
                fwdAddr_q  <= remoteTargetAddressZero_q;
            end
            else if (xferValid)
                fwdRefused_q <= 1'h1;
        end
    end
endmodule

// File: test/link_status_alias_regs_properties.sv
// Port checker for the link status register slice.
// Assumes it is bound to the slice and sees only its ports.
`timescale 1ns/1ns
module link_status_alias_regs_properties
    import link_status_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic       regWrEn,
    input wire logic       regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData_q,
    input wire logic       linkDetectIn,
    input wire logic       videoClockIn,
    input wire logic       xferValid,
    input wire logic       fwdValid_q,
    input wire logic       fwdRefused_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    logic       readHigh_q;
    logic       highSeen_q;
    logic [7:0] lastHigh_q;

    // Last high count byte read, forgotten when software clears the count
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            readHigh_q <= 1'h0;
            highSeen_q <= 1'h0;
            lastHigh_q <= 8'h00;
        end
        else
        begin
            readHigh_q <= regRdEn && regAddr == ADDR_CRC_HIGH;
            if (regWrEn && regAddr == ADDR_RESET_CTRL
                && regWrData[CRC_RESET_BIT])
                highSeen_q <= 1'h0;
            else if (readHigh_q)
            begin
                highSeen_q <= 1'h1;
                lastHigh_q <= regRdData_q;
            end
        end
    end

    chk_one_answer: assert property (
        xferValid |=> fwdValid_q != fwdRefused_q)
        else $error("transfer answer not single");
    chk_no_idle_answer: assert property (
        !xferValid |=> !(fwdValid_q || fwdRefused_q))
        else $error("answer without transfer");
    chk_status_reserved: assert property (
        regRdEn && regAddr == ADDR_STATUS |=> regRdData_q[7:5] == 3'h0)
        else $error("status top bits set");
    chk_alias_low_bit: assert property (
        regRdEn && regAddr == ADDR_ALIAS |=> !regRdData_q[0])
        else $error("alias bit zero set");
    chk_ctrl_reads_zero: assert property (
        regRdEn && regAddr == ADDR_RESET_CTRL |=> regRdData_q == 8'h00)
        else $error("reset control reads nonzero");
    chk_link_bit: assert property (
        $stable(linkDetectIn)[*5] ##0 (regRdEn && regAddr == ADDR_STATUS)
        |=> regRdData_q[0] == linkDetectIn)
        else $error("link bit wrong");
    chk_clock_bit: assert property (
        $stable(videoClockIn)[*5] ##0 (regRdEn && regAddr == ADDR_STATUS)
        |=> regRdData_q[2] == videoClockIn)
        else $error("clock bit wrong");
    chk_read_holds: assert property (
        !regRdEn |=> $stable(regRdData_q))
        else $error("read data moved");
    chk_count_no_wrap: assert property (
        readHigh_q && highSeen_q |-> regRdData_q >= lastHigh_q)
        else $error("count high byte fell");
endmodule

// File: test/remote_deserializer_model.sv
// Far end of the serial link: link level, self-test, CRC errors.
// Assumes the bench calls its tasks; lines change at falling edges.
`timescale 1ns/1ns
module remote_deserializer_model (
    input  wire logic core_clk,
    output logic      linkDetect,
    output logic      crcError,
    output logic      selftestActive
);
    initial {linkDetect, crcError, selftestActive} = 3'h0;
    task automatic set_lines(input logic link, input logic testOn);
        @(negedge core_clk);
        linkDetect = link;
        selftestActive = testOn;
    endtask
    // Gap counts falling edges; even a gap of 1 holds each level a whole cycle for the two-flop sync
    task automatic send_errors(input int n, input int gap);
        repeat (n)
        begin
            @(negedge core_clk);
            crcError = 1'b1;
            repeat (gap) @(negedge core_clk);
            crcError = 1'b0;
            repeat (gap) @(negedge core_clk);
        end
    endtask
endmodule

// File: test/link_status_alias_regs_tb.sv
// Bench for the link status slice with a far-end link model.
// Assumes the slice package; inputs change at falling edges.
`timescale 1ns/1ns
module link_status_alias_regs_tb;
    import link_status_pkg::*;
    logic       core_clk, rstn, regWrEn, regRdEn, videoClockIn, xferValid;
    logic       linkDetectIn, crcErrorIn, selftestActiveIn;
    logic       fwdValid_q, fwdRefused_q;
    logic [7:0] regAddr, regWrData, regRdData_q;
    logic [6:0] xferAddr, fwdAddr_q;
    int         errors = 0, comparisons = 0, cycles = 0;
    link_status_alias_regs dut (.core_clk, .rstn, .regWrEn, .regRdEn,
        .regAddr, .regWrData, .regRdData_q, .linkDetectIn, .videoClockIn,
        .crcErrorIn, .selftestActiveIn, .xferAddr, .xferValid,
        .fwdValid_q, .fwdAddr_q, .fwdRefused_q);
    remote_deserializer_model far (.core_clk, .linkDetect(linkDetectIn),
        .crcError(crcErrorIn), .selftestActive(selftestActiveIn));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge core_clk);
        regWrEn = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        regRdEn = 1'b1;
        regAddr = a;
        @(negedge core_clk);
        regRdEn = 1'b0;
        check(regRdData_q, exp);
    endtask
    // Refused shows as 7F so one compare covers both answers
    task automatic xfer(input logic [6:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        xferValid = 1'b1;
        xferAddr = a;
        @(negedge core_clk);
        xferValid = 1'b0;
        check({fwdValid_q, fwdRefused_q ? 7'h7F : fwdAddr_q}, exp);
    endtask
    task automatic t_reset;
        rdc(ADDR_ALIAS, 8'h00);
        rdc(ADDR_CRC_LOW, 8'h00);
        rdc(ADDR_CRC_HIGH, 8'h00);
        rdc(ADDR_STATUS, 8'h00);
        rdc(ADDR_RESET_CTRL, 8'h00);
        rdc(8'h09, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_remap;
        xfer(7'h00, 8'h7F);
        wr(ADDR_TARGET, 8'hB4);
        wr(ADDR_ALIAS, 8'h63);
        rdc(ADDR_ALIAS, 8'h62);
        xfer(7'h31, 8'hDA);
        xfer(7'h30, 8'h7F);
        wr(ADDR_ALIAS, 8'h00);
        xfer(7'h00, 8'h7F);
        $display("remap test done");
    endtask
    task automatic t_status;
        far.set_lines(1'b1, 1'b0);
        videoClockIn = 1'b1;
        idle(6);
        rdc(ADDR_STATUS, 8'h05);
        far.send_errors(3, 2);
        idle(6);
        rdc(ADDR_CRC_LOW, 8'h03);
        rdc(ADDR_CRC_HIGH, 8'h00);
        rdc(ADDR_STATUS, 8'h07);
        far.set_lines(1'b1, 1'b1);
        idle(6);
        far.send_errors(1, 3);
        idle(6);
        rdc(ADDR_STATUS, 8'h0F);
        far.set_lines(1'b1, 1'b0);
        idle(2);
        far.set_lines(1'b1, 1'b1);
        idle(6);
        rdc(ADDR_STATUS, 8'h07);
        far.set_lines(1'b0, 1'b0);
        idle(6);
        rdc(ADDR_STATUS, 8'h14);
        far.set_lines(1'b1, 1'b0);
        idle(6);
        rdc(ADDR_STATUS, 8'h15);
        wr(ADDR_RESET_CTRL, 8'h20);
        videoClockIn = 1'b0;
        idle(6);
        rdc(ADDR_STATUS, 8'h01);
        rdc(ADDR_CRC_LOW, 8'h00);
        $display("status test done");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Whole run needs about 150 cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            report_and_stop;
        end
    end
    initial
    begin
        {rstn, regWrEn, regRdEn, videoClockIn, xferValid} = 5'h00;
        {regAddr, regWrData, xferAddr} = 23'h0;
        idle(20);
        rstn = 1'b1;
        idle(3);
        t_reset;
        t_remap;
        t_status;
        report_and_stop;
    end
endmodule
bind link_status_alias_regs link_status_alias_regs_properties chk (
    .core_clk, .rstn, .regWrEn, .regRdEn, .regAddr, .regWrData,
    .regRdData_q, .linkDetectIn, .videoClockIn, .xferValid, .fwdValid_q,
    .fwdRefused_q);
